// ==== rtl/mcd_pkg.sv ====
// Constants, types and decode function for the instruction decoder
// Assumes a single clock; one instruction cycle is four clocks
// Overview of operation
// RULE1: Instructions are single 14-bit words holding opcode and all operands.
// RULE2: Every instruction takes one cycle except calls, returns, jumps, skips, indirect.
// RULE3: Literal call and accumulator-computed call take two cycles.
// RULE4: Return, return with literal and interrupt exit take two cycles.
// RULE5: Absolute, relative and accumulator jumps take two cycles; taken skips too.
// RULE6: Indirect access with pointer into program memory adds one cycle.
// RULE7: One instruction cycle spans four oscillator clocks.
// RULE8: File writes read the register first, modify, then store.
// RULE9: Destination bit 0 sends result to accumulator, 1 to file register.
// RULE10: File operand is 7 bits, locations 0x00 to 0x7f in bank.
// RULE11: Add, add with carry, subtract with borrow update carry, half carry, zero.
// RULE12: AND, OR, XOR with file register affect only zero.
// RULE13: Rotates update carry only; shifts update carry and zero.
// RULE14: Decrement or increment and skip on zero; flags unchanged.
// RULE15: Bit clear and set select one of eight bits; no flags.
// RULE16: Bit tests skip on clear or set; two cycles when skipping.
// RULE17: Add literal and literal minus accumulator update carry, half carry, zero.
// RULE18: Literal AND, OR, XOR affect only zero.
// RULE19: Load upper pc latch, bank select and accumulator from literals.
// RULE20: Don't-care bits are ignored whatever their value.
// RULE21: Second cycle of a jump or taken skip is a no-operation.
// RULE22: Zero flag follows whether the 8-bit result is zero.
// RULE23: Classify by two top bits, then opcode bits, then extract operands.
package mcd_pkg;
	localparam int OSC_PER_ICYC = 4;
	localparam int PH_W = 2;
	localparam logic [1:0] PH_FETCH = 2'h0;
	localparam logic [1:0] PH_READ = 2'h1;
	localparam logic [1:0] PH_CALC = 2'h2;
	localparam logic [1:0] PH_WRITE = 2'h3;
	localparam int IW = 14;
	localparam int DW = 8;
	localparam int FW = 7;
	localparam int BANKW = 6;
	localparam int UPCW = 7;
	localparam int DEST_BIT = 7;
	localparam int BIT_LSB = 7;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [7:0] CTL_RETURN = 8'h08;
	localparam logic [7:0] CTL_IEXIT = 8'h09;
	localparam logic [7:0] CTL_COMPUTED_SUBROUTINE_JUMP = 8'h0a;
	localparam logic [7:0] CTL_BRW = 8'h0b;

	typedef enum logic [4:0] {
		ALU_ADD, ALU_ADDC, ALU_SUB, ALU_SUBB, ALU_LSUB, ALU_AND, ALU_OR, ALU_XOR,
		ALU_RLC, ALU_RRC, ALU_ASR, ALU_LSL, ALU_LSR, ALU_DEC, ALU_INC, ALU_BCLR,
		ALU_BSET, ALU_PASSA, ALU_PASSW, ALU_ZERO, ALU_COM, ALU_SWAP
	} mcd_alu_e;
	typedef enum logic [1:0] {SK_NONE, SK_ZERO, SK_BCLR, SK_BSET} mcd_skip_e;
	typedef enum logic [1:0] {ST_EXEC = 2'b00, ST_EXTRA = 2'b10, ST_NOP = 2'b01} mcd_state_e;
	typedef struct packed {
		mcd_alu_e op;
		logic use_file;
		logic use_lit;
		logic wr_acc;
		logic wr_file;
		logic upd_c;
		logic upd_dc;
		logic upd_z;
		mcd_skip_e skip;
		logic two_cyc;
		logic ld_bank;
		logic ld_upc;
	} mcd_dec_s;

	function automatic mcd_dec_s mcd_decode(input logic [IW-1:0] ir);
		mcd_dec_s d;
		logic bytef;
		d = '0;
		d.op = ALU_PASSA;
		d.skip = SK_NONE;
		bytef = 1'b0;
		case (ir[13:12])
			2'b00: begin
				bytef = 1'b1;
				case (ir[11:8])
					4'h0: begin
						if (ir[DEST_BIT]) begin
							d.op = ALU_PASSW;
						end else begin
							bytef = 1'b0;
							d.two_cyc = (ir[7:0] == CTL_RETURN) || (ir[7:0] == CTL_IEXIT) ||
								(ir[7:0] == CTL_COMPUTED_SUBROUTINE_JUMP) || (ir[7:0] == CTL_BRW); // see RULE3 RULE4 RULE5
						end
					end
					4'h1: begin
						d.op = ALU_ZERO;
						d.upd_z = 1'b1;
						if (!ir[DEST_BIT]) begin
							bytef = 1'b0;
							d.ld_bank = ir[6]; // see RULE19
							d.wr_acc = (ir[6:2] == 5'h00); // see RULE20
							d.upd_z = d.wr_acc;
						end
					end
					4'h2: begin d.op = ALU_SUB; d.upd_c = 1'b1; d.upd_dc = 1'b1; d.upd_z = 1'b1; end
					4'h3: begin d.op = ALU_DEC; d.upd_z = 1'b1; end
					4'h4: begin d.op = ALU_OR; d.upd_z = 1'b1; end // see RULE12
					4'h5: begin d.op = ALU_AND; d.upd_z = 1'b1; end // see RULE12
					4'h6: begin d.op = ALU_XOR; d.upd_z = 1'b1; end // see RULE12
					4'h7: begin d.op = ALU_ADD; d.upd_c = 1'b1; d.upd_dc = 1'b1; d.upd_z = 1'b1; end // see RULE11
					4'h8: begin d.op = ALU_PASSA; d.upd_z = 1'b1; end
					4'h9: begin d.op = ALU_COM; d.upd_z = 1'b1; end
					4'ha: begin d.op = ALU_INC; d.upd_z = 1'b1; end
					4'hb: begin d.op = ALU_DEC; d.skip = SK_ZERO; end // see RULE14
					4'hc: begin d.op = ALU_RRC; d.upd_c = 1'b1; end // see RULE13
					4'hd: begin d.op = ALU_RLC; d.upd_c = 1'b1; end // see RULE13
					4'he: d.op = ALU_SWAP;
					default: begin d.op = ALU_INC; d.skip = SK_ZERO; end // see RULE14
				endcase
			end
			2'b01: begin
				d.use_file = 1'b1; // see RULE15 RULE16
				case (ir[11:10])
					2'b00: begin d.op = ALU_BCLR; d.wr_file = 1'b1; end
					2'b01: begin d.op = ALU_BSET; d.wr_file = 1'b1; end
					2'b10: d.skip = SK_BCLR;
					default: d.skip = SK_BSET;
				endcase
			end
			2'b10: d.two_cyc = 1'b1; // see RULE3 RULE5
			default: begin
				case (ir[11:8])
					4'h0: begin d.use_lit = 1'b1; d.wr_acc = 1'b1; end // see RULE19
					4'h1: d.ld_upc = ir[DEST_BIT]; // see RULE19
					4'h2, 4'h3: d.two_cyc = 1'b1; // see RULE5
					4'h4: begin d.use_lit = 1'b1; d.wr_acc = 1'b1; d.two_cyc = 1'b1; end // see RULE4
					4'h5: begin bytef = 1'b1; d.op = ALU_LSL; d.upd_c = 1'b1; d.upd_z = 1'b1; end
					4'h6: begin bytef = 1'b1; d.op = ALU_LSR; d.upd_c = 1'b1; d.upd_z = 1'b1; end
					4'h7: begin bytef = 1'b1; d.op = ALU_ASR; d.upd_c = 1'b1; d.upd_z = 1'b1; end
					4'h8: d.op = ALU_OR;
					4'h9: d.op = ALU_AND;
					4'ha: d.op = ALU_XOR;
					4'hb: begin bytef = 1'b1; d.op = ALU_SUBB; end
					4'hc: d.op = ALU_LSUB;
					4'hd: begin bytef = 1'b1; d.op = ALU_ADDC; end
					4'he: d.op = ALU_ADD;
					default: d.op = ALU_PASSA;
				endcase
				if (ir[11]) begin
					d.use_lit = !bytef && (ir[11:8] != 4'hf);
					d.wr_acc = d.use_lit; // see RULE17 RULE18
					d.upd_z = d.use_lit || bytef;
					d.upd_c = (d.op == ALU_ADD) || (d.op == ALU_LSUB) || bytef; // see RULE11 RULE17
					d.upd_dc = d.upd_c;
				end
			end
		endcase
		if (bytef) begin
			d.use_file = 1'b1; // see RULE8 RULE23
			d.wr_file = ir[DEST_BIT]; // see RULE9
			d.wr_acc = !ir[DEST_BIT];
		end
		return d;
	endfunction
endpackage

// ==== rtl/mcd_phase.sv ====
// Phase counter that splits each instruction cycle into oscillator clocks
// Assumes clk is the oscillator clock
`timescale 1ns/1ps
`default_nettype none
module mcd_phase import mcd_pkg::*; #(
	parameter int CYC = OSC_PER_ICYC
) (
	input wire logic clk,
	input wire logic rst_n,
	output logic [PH_W-1:0] phase_q
);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_q <= PH_FETCH;
		end else if (phase_q == PH_W'(CYC - 1)) begin
			phase_q <= PH_FETCH; // see RULE7
		end else begin
			phase_q <= phase_q + 1'b1;
		end
	end

	a_phase_wrap: assert property (@(posedge clk) disable iff (!rst_n) // see RULE7
		phase_q == PH_WRITE |=> phase_q == PH_FETCH ##3 phase_q == PH_WRITE)
		else $error("phase does not wrap every four clocks");
endmodule
`default_nettype wire

// ==== rtl/mcd_alu.sv ====
// Combinational operand unit for byte, bit and literal operations
// Assumes operands are stable during the write phase
`timescale 1ns/1ps
`default_nettype none
module mcd_alu import mcd_pkg::*; (
	input wire mcd_alu_e op,
	input wire logic [DW-1:0] a,
	input wire logic [DW-1:0] w,
	input wire logic cin,
	input wire logic [2:0] bsel,
	output logic [DW-1:0] res,
	output logic c_out,
	output logic dc_out,
	output logic bit_val
);
	logic [DW-1:0] x;
	logic [DW-1:0] y;
	logic ci;
	logic [DW:0] sum;
	logic [4:0] nib;

	always_comb begin
		x = a;
		y = w;
		ci = 1'b0;
		case (op)
			ALU_ADDC: ci = cin;
			ALU_SUB, ALU_LSUB: begin y = ~w; ci = 1'b1; end
			ALU_SUBB: begin y = ~w; ci = cin; end
			default: ci = 1'b0;
		endcase
		sum = {1'b0, x} + {1'b0, y} + {{DW{1'b0}}, ci};
		nib = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
	end

	always_comb begin
		res = a;
		c_out = sum[DW];
		dc_out = nib[4];
		bit_val = a[bsel];
		case (op)
			ALU_ADD, ALU_ADDC, ALU_SUB, ALU_SUBB, ALU_LSUB: res = sum[DW-1:0];
			ALU_AND: res = a & w;
			ALU_OR: res = a | w;
			ALU_XOR: res = a ^ w;
			ALU_RLC: begin res = {a[6:0], cin}; c_out = a[7]; end
			ALU_RRC: begin res = {cin, a[7:1]}; c_out = a[0]; end
			ALU_ASR: begin res = {a[7], a[7:1]}; c_out = a[0]; end
			ALU_LSL: begin res = {a[6:0], 1'b0}; c_out = a[7]; end
			ALU_LSR: begin res = {1'b0, a[7:1]}; c_out = a[0]; end
			ALU_DEC: res = a - 8'h01;
			ALU_INC: res = a + 8'h01;
			ALU_BCLR: res = a & ~(8'h01 << bsel);
			ALU_BSET: res = a | (8'h01 << bsel);
			ALU_PASSW: res = w;
			ALU_ZERO: res = 8'h00;
			ALU_COM: res = ~a;
			ALU_SWAP: res = {a[3:0], a[7:4]};
			default: res = a;
		endcase
	end
endmodule
`default_nettype wire

// ==== rtl/mcd_core.sv ====
// Instruction decoder and sequencer for the 8-bit accumulator core
// Assumes program memory and file registers sit on the same clock
`timescale 1ns/1ps
`default_nettype none
module mcd_core import mcd_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [IW-1:0] instr_word,
	input wire logic indirect_prog,
	input wire logic [DW-1:0] file_rdata,
	output logic [PH_W-1:0] phase_q,
	output logic fetch_take_q,
	output logic [FW-1:0] file_addr_q,
	output logic file_rd_q,
	output logic file_wr_q,
	output logic [DW-1:0] file_wdata_q,
	output logic [DW-1:0] working_accumulator_q,
	output logic carry_q,
	output logic half_carry_flag_q,
	output logic zero_q,
	output logic [BANKW-1:0] bank_select_reg_q,
	output logic [UPCW-1:0] upper_pc_latch_q,
	output logic nop_cycle_q
);
	logic [IW-1:0] ir_q;
	mcd_dec_s dec_q;
	logic ind_q;
	mcd_state_e state_q;
	mcd_state_e state_d;
	logic exec;
	logic [DW-1:0] alu_a;
	logic [DW-1:0] alu_res;
	logic alu_c;
	logic alu_dc;
	logic alu_bit;
	logic skip_hit;
	logic wb;

	mcd_phase u_phase (
		.clk(clk),
		.rst_n(rst_n),
		.phase_q(phase_q)
	);

	assign exec = (state_q == ST_EXEC);
	assign wb = exec && (phase_q == PH_WRITE);
	assign alu_a = dec_q.use_lit ? ir_q[DW-1:0] : file_rdata;

	mcd_alu u_alu (
		.op(dec_q.op),
		.a(alu_a),
		.w(working_accumulator_q),
		.cin(carry_q),
		.bsel(ir_q[BIT_LSB+2:BIT_LSB]),
		.res(alu_res),
		.c_out(alu_c),
		.dc_out(alu_dc),
		.bit_val(alu_bit)
	);

	always_comb begin
		case (dec_q.skip)
			SK_ZERO: skip_hit = (alu_res == 8'h00); // see RULE14
			SK_BCLR: skip_hit = !alu_bit; // see RULE16
			SK_BSET: skip_hit = alu_bit; // see RULE16
			default: skip_hit = 1'b0;
		endcase
	end

	// Word is taken whole at the start of an executing cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ir_q <= '0;
			dec_q <= '0;
			ind_q <= 1'b0;
			fetch_take_q <= 1'b0;
		end else begin
			fetch_take_q <= exec && (phase_q == PH_FETCH);
			if (exec && (phase_q == PH_FETCH)) begin
				ir_q <= instr_word; // see RULE1
				dec_q <= mcd_decode(instr_word); // see RULE23
				ind_q <= indirect_prog;
			end
		end
	end

	// Read always precedes write, even for pure stores
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			file_addr_q <= '0;
			file_rd_q <= 1'b0;
		end else begin
			file_rd_q <= exec && (phase_q == PH_READ) && dec_q.use_file; // see RULE8
			if (exec && (phase_q == PH_READ)) begin
				file_addr_q <= ir_q[FW-1:0]; // see RULE10
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			file_wr_q <= 1'b0;
			file_wdata_q <= '0;
		end else begin
			file_wr_q <= wb && dec_q.wr_file; // see RULE8 RULE9
			if (wb && dec_q.wr_file) begin
				file_wdata_q <= alu_res;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			working_accumulator_q <= ACC_RST;
		end else if (wb && dec_q.wr_acc) begin
			working_accumulator_q <= dec_q.use_lit && (dec_q.op == ALU_PASSA) ?
				ir_q[DW-1:0] : alu_res; // see RULE9 RULE19
		end
	end

	// Flags only move for the classes that list them
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			carry_q <= 1'b0;
			half_carry_flag_q <= 1'b0;
			zero_q <= 1'b0;
		end else if (wb) begin
			if (dec_q.upd_c) begin
				carry_q <= alu_c; // see RULE11 RULE13 RULE17
			end
			if (dec_q.upd_dc) begin
				half_carry_flag_q <= alu_dc; // see RULE11 RULE17
			end
			if (dec_q.upd_z) begin
				zero_q <= (alu_res == 8'h00); // see RULE22 RULE12 RULE18
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bank_select_reg_q <= '0;
			upper_pc_latch_q <= '0;
		end else if (wb) begin
			if (dec_q.ld_bank) begin
				bank_select_reg_q <= ir_q[BANKW-1:0]; // see RULE19
			end
			if (dec_q.ld_upc) begin
				upper_pc_latch_q <= ir_q[UPCW-1:0]; // see RULE19
			end
		end
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_EXEC: begin
				if (dec_q.two_cyc || skip_hit) begin
					state_d = ST_NOP; // see RULE2 RULE5 RULE21
				end else if (ind_q) begin
					state_d = ST_EXTRA; // see RULE6
				end else begin
					state_d = ST_EXEC;
				end
			end
			ST_NOP: state_d = ind_q ? ST_EXTRA : ST_EXEC;
			ST_EXTRA: state_d = ST_EXEC;
			default: state_d = ST_EXEC;
		endcase
	end

	// State moves only at the end of an instruction cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_EXEC;
			nop_cycle_q <= 1'b0;
		end else if (phase_q == PH_WRITE) begin
			state_q <= state_d;
			nop_cycle_q <= (state_d != ST_EXEC);
		end
	end

	a_rd_before_wr: assert property (@(posedge clk) disable iff (!rst_n) // see RULE8
		file_wr_q |-> $past(file_rd_q, 2))
		else $error("file write without prior read");

	a_rd_addr_field: assert property (@(posedge clk) disable iff (!rst_n) // see RULE10
		file_rd_q |-> file_addr_q == ir_q[6:0])
		else $error("read address not the operand field");

	a_dest_route: assert property (@(posedge clk) disable iff (!rst_n) // see RULE9
		wb && dec_q.use_file && ir_q[13:12] == 2'b00 && ir_q[11:8] != 4'h0 && ir_q[11:8] != 4'h1
		|=> file_wr_q == $past(ir_q[7]))
		else $error("destination bit misrouted");

	a_two_cyc_nop: assert property (@(posedge clk) disable iff (!rst_n) // see RULE3
		wb && dec_q.two_cyc |=> state_q == ST_NOP && nop_cycle_q ##4 state_q != ST_NOP)
		else $error("two-cycle instruction not followed by one idle cycle");

	a_skip_taken: assert property (@(posedge clk) disable iff (!rst_n) // see RULE16
		wb && dec_q.skip != SK_NONE && skip_hit |=> state_q == ST_NOP)
		else $error("taken skip did not idle");

	a_nop_quiet: assert property (@(posedge clk) disable iff (!rst_n) // see RULE21
		state_q == ST_NOP |-> !fetch_take_q && !file_rd_q ##1 !(phase_q == PH_FETCH && file_wr_q))
		else $error("idle cycle is not quiet");

	a_extra_cycle: assert property (@(posedge clk) disable iff (!rst_n) // see RULE6
		wb && ind_q && !dec_q.two_cyc && !skip_hit |=> state_q == ST_EXTRA ##4 state_q == ST_EXEC)
		else $error("indirect access missing extra cycle");

	a_zero_flag: assert property (@(posedge clk) disable iff (!rst_n) // see RULE22
		wb && dec_q.upd_z |=> zero_q == ($past(alu_res) == 8'h00))
		else $error("zero flag disagrees with result");

	a_logic_carry: assert property (@(posedge clk) disable iff (!rst_n) // see RULE12
		wb && (dec_q.op == ALU_AND || dec_q.op == ALU_OR || dec_q.op == ALU_XOR)
		|=> $stable(carry_q) && $stable(half_carry_flag_q))
		else $error("logic operation touched carry");

	a_one_fetch: assert property (@(posedge clk) disable iff (!rst_n) // see RULE2
		fetch_take_q |-> ##1 !fetch_take_q [*3])
		else $error("more than one fetch per cycle");

	a_fetch_phase: assert property (@(posedge clk) disable iff (!rst_n) // see RULE1
		fetch_take_q |-> phase_q == PH_READ)
		else $error("fetch strobe outside its phase");

	a_rd_phase: assert property (@(posedge clk) disable iff (!rst_n) // see RULE8
		file_rd_q |-> phase_q == PH_CALC)
		else $error("file read outside its phase");

	a_wr_phase: assert property (@(posedge clk) disable iff (!rst_n) // see RULE8
		file_wr_q |-> phase_q == PH_FETCH)
		else $error("file write outside its phase");

	a_bit_no_flags: assert property (@(posedge clk) disable iff (!rst_n) // see RULE15
		wb && (dec_q.op == ALU_BCLR || dec_q.op == ALU_BSET)
		|=> $stable(carry_q) && $stable(half_carry_flag_q) && $stable(zero_q))
		else $error("bit operation touched a flag");

	a_skip_no_flags: assert property (@(posedge clk) disable iff (!rst_n) // see RULE14
		wb && dec_q.skip != SK_NONE
		|=> $stable(carry_q) && $stable(half_carry_flag_q) && $stable(zero_q))
		else $error("skip operation touched a flag");

	a_rotate_flags: assert property (@(posedge clk) disable iff (!rst_n) // see RULE13
		wb && (dec_q.op == ALU_RLC || dec_q.op == ALU_RRC)
		|=> $stable(zero_q) && $stable(half_carry_flag_q))
		else $error("rotate touched zero or half carry");

	a_shift_dc: assert property (@(posedge clk) disable iff (!rst_n) // see RULE13
		wb && (dec_q.op == ALU_ASR || dec_q.op == ALU_LSL || dec_q.op == ALU_LSR)
		|=> $stable(half_carry_flag_q))
		else $error("shift touched half carry");

	a_lit_load: assert property (@(posedge clk) disable iff (!rst_n) // see RULE19
		wb && dec_q.use_lit && dec_q.op == ALU_PASSA |=> working_accumulator_q == $past(ir_q[DW-1:0]))
		else $error("literal not loaded into accumulator");

	a_bank_load: assert property (@(posedge clk) disable iff (!rst_n) // see RULE19
		wb && dec_q.ld_bank |=> bank_select_reg_q == $past(ir_q[BANKW-1:0]))
		else $error("bank select not loaded from literal");

	a_upc_load: assert property (@(posedge clk) disable iff (!rst_n) // see RULE19
		wb && dec_q.ld_upc |=> upper_pc_latch_q == $past(ir_q[UPCW-1:0]))
		else $error("upper pc latch not loaded from literal");

	a_file_dest_acc: assert property (@(posedge clk) disable iff (!rst_n) // see RULE9
		wb && dec_q.wr_file |=> $stable(working_accumulator_q))
		else $error("file destination changed the accumulator");

	a_acc_dest_file: assert property (@(posedge clk) disable iff (!rst_n) // see RULE9
		wb && dec_q.use_file && !dec_q.wr_file |=> !file_wr_q)
		else $error("accumulator destination wrote the file");

	a_one_cycle: assert property (@(posedge clk) disable iff (!rst_n) // see RULE2
		wb && !dec_q.two_cyc && !skip_hit && !ind_q |=> state_q == ST_EXEC)
		else $error("single-cycle instruction took longer");

	a_idle_regs: assert property (@(posedge clk) disable iff (!rst_n) // see RULE21
		state_q == ST_NOP
		|=> $stable(working_accumulator_q) && $stable(zero_q) && $stable(carry_q))
		else $error("idle cycle changed core state");

	a_zero_acc: assert property (@(posedge clk) disable iff (!rst_n) // see RULE20
		wb && dec_q.op == ALU_ZERO && dec_q.wr_acc |=> working_accumulator_q == 8'h00 && zero_q)
		else $error("accumulator clear failed");

	a_extra_quiet: assert property (@(posedge clk) disable iff (!rst_n) // see RULE6
		state_q == ST_EXTRA |-> !fetch_take_q && !file_rd_q)
		else $error("extra cycle is not quiet");

	a_wr_addr: assert property (@(posedge clk) disable iff (!rst_n) // see RULE10
		file_wr_q |-> file_addr_q == $past(ir_q[FW-1:0]))
		else $error("write address not the operand field");

	a_skip_write: assert property (@(posedge clk) disable iff (!rst_n) // see RULE14
		wb && dec_q.skip == SK_ZERO && dec_q.wr_file |=> file_wr_q)
		else $error("skip on zero lost its file write");
endmodule
`default_nettype wire

// ==== dv/mcd_prog_model.sv ====
// Program memory and file register model facing the decoder core
// Assumes the bench loads words and file bytes while reset is held
`timescale 1ns/1ps
`default_nettype none
module mcd_prog_model import mcd_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic fetch_take_q,
	input wire logic [FW-1:0] file_addr_q,
	input wire logic file_rd_q,
	input wire logic file_wr_q,
	input wire logic [DW-1:0] file_wdata_q,
	input wire logic nop_cycle_q,
	output logic [IW-1:0] instr_word,
	output logic indirect_prog,
	output logic [DW-1:0] file_rdata
);
	logic [IW-1:0] mem [0:31];
	logic ind_mem [0:31];
	logic [DW-1:0] fmem [0:127];
	logic rd_q;
	int ptr;
	int n_rd;
	int n_wr;
	int n_nop;
	// Whole words only; past the end a plain no-op
	assign instr_word = (ptr < 32) ? mem[ptr] : '0;
	assign indirect_prog = (ptr < 32) ? ind_mem[ptr] : 1'b0;
	// Data valid only in the clock after the read strobe, inverted junk otherwise
	assign file_rdata = rd_q ? fmem[file_addr_q] : ~fmem[file_addr_q];
	// Plain always: the bench also presets fmem while reset is held
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ptr <= 0;
			n_rd <= 0;
			n_wr <= 0;
			n_nop <= 0;
			rd_q <= 1'b0;
		end else begin
			rd_q <= file_rd_q;
			if (fetch_take_q) ptr <= ptr + 1;
			if (file_rd_q) n_rd <= n_rd + 1;
			if (nop_cycle_q) n_nop <= n_nop + 1;
			if (file_wr_q) begin
				n_wr <= n_wr + 1;
				fmem[file_addr_q] <= file_wdata_q;
			end
		end
	end
endmodule
`default_nettype wire

// ==== dv/mcu_core_instruction_decoder_bench.sv ====
// Self-checking bench for the instruction decoder core
// Assumes the program memory model answers every fetch and file access
`timescale 1ns/1ps
`default_nettype none
module mcu_core_instruction_decoder_bench import mcd_pkg::*;;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [IW-1:0] instr_word;
	logic indirect_prog;
	logic [DW-1:0] file_rdata;
	logic [PH_W-1:0] phase_q;
	logic fetch_take_q;
	logic [FW-1:0] file_addr_q;
	logic file_rd_q;
	logic file_wr_q;
	logic [DW-1:0] file_wdata_q;
	logic [DW-1:0] working_accumulator_q;
	logic carry_q;
	logic half_carry_flag_q;
	logic zero_q;
	logic [BANKW-1:0] bank_select_reg_q;
	logic [UPCW-1:0] upper_pc_latch_q;
	logic nop_cycle_q;
	int bad_count = 0;
	int checked = 0;

	always #4 clk = ~clk;

	mcd_core dut_u (.clk(clk), .rst_n(rst_n), .instr_word(instr_word),
		.indirect_prog(indirect_prog), .file_rdata(file_rdata), .phase_q(phase_q),
		.fetch_take_q(fetch_take_q), .file_addr_q(file_addr_q), .file_rd_q(file_rd_q),
		.file_wr_q(file_wr_q), .file_wdata_q(file_wdata_q),
		.working_accumulator_q(working_accumulator_q), .carry_q(carry_q),
		.half_carry_flag_q(half_carry_flag_q), .zero_q(zero_q),
		.bank_select_reg_q(bank_select_reg_q), .upper_pc_latch_q(upper_pc_latch_q),
		.nop_cycle_q(nop_cycle_q));

	mcd_prog_model prog_u (.clk(clk), .rst_n(rst_n), .fetch_take_q(fetch_take_q),
		.file_addr_q(file_addr_q), .file_rd_q(file_rd_q), .file_wr_q(file_wr_q),
		.file_wdata_q(file_wdata_q), .nop_cycle_q(nop_cycle_q), .instr_word(instr_word),
		.indirect_prog(indirect_prog), .file_rdata(file_rdata));

	task automatic complete_run();
		$display("Checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, got);
			bad_count++;
		end
	endtask

	function automatic logic [7:0] flg();
		return {5'h00, carry_q, half_carry_flag_q, zero_q};
	endfunction

	// Holds reset and loads a fresh program; unused slots are no-ops
	task automatic prog(input logic [IW-1:0] w [$]);
		rst_n = 1'b0;
		for (int i = 0; i < 32; i++) begin
			prog_u.mem[i] = (i < w.size()) ? w[i] : '0;
			prog_u.ind_mem[i] = 1'b0;
		end
	endtask

	// Ends on the first edge after release, where word 0 is taken
	task automatic go();
		repeat (20) @(posedge clk);
		#1 rst_n = 1'b1;
		@(posedge clk);
	endtask

	task automatic step(input int n);
		repeat (4 * n) @(posedge clk);
		#1;
	endtask

	task automatic lit_ops();
		prog({14'h303c, 14'h3ec4, 14'h385a, 14'h390f, 14'h3a0a, 14'h3005, 14'h3c03,
			14'h0103, 14'h0155, 14'h31da});
		go();
		step(2);
		chk("acc", 8'h00, working_accumulator_q);
		chk("flags", 8'h07, flg());
		step(5);
		chk("acc", 8'hfe, working_accumulator_q);
		chk("flags", 8'h00, flg());
		step(3);
		chk("acc", 8'h00, working_accumulator_q);
		chk("flags", 8'h01, flg());
		chk("bank", 8'h15, {2'b00, bank_select_reg_q});
		chk("upper pc", 8'h5a, {1'b0, upper_pc_latch_q});
	endtask

	task automatic byte_ops();
		prog({14'h3001, 14'h07ff, 14'h057f, 14'h0400, 14'h0680, 14'h0085, 14'h3d7f, 14'h3bff});
		prog_u.fmem[127] = 8'h0f;
		prog_u.fmem[0] = 8'h80;
		prog_u.fmem[5] = 8'h33;
		go();
		step(2);
		chk("file 7f", 8'h10, prog_u.fmem[127]);
		chk("flags", 8'h02, flg());
		step(6);
		chk("acc", 8'h90, working_accumulator_q);
		chk("file 7f", 8'h7f, prog_u.fmem[127]);
		chk("file 00", 8'h00, prog_u.fmem[0]);
		chk("file 05", 8'h80, prog_u.fmem[5]);
		chk("flags", 8'h00, flg());
		chk("reads", 8'd7, 8'(prog_u.n_rd));
		chk("writes", 8'd4, 8'(prog_u.n_wr));
	endtask

	task automatic shift_ops();
		prog({14'h3581, 14'h0c01, 14'h3781, 14'h3681, 14'h0d01, 14'h1781, 14'h1501, 14'h1381});
		prog_u.fmem[1] = 8'h81;
		go();
		step(5);
		chk("file 01", 8'h00, prog_u.fmem[1]);
		chk("acc", 8'h01, working_accumulator_q);
		chk("flags", 8'h01, flg());
		step(3);
		chk("file 01", 8'h04, prog_u.fmem[1]);
		chk("flags", 8'h01, flg());
	endtask

	task automatic skip_ops();
		prog({14'h0b82, 14'h0f83, 14'h1c03, 14'h1803, 14'h3477, 14'h0b03});
		prog_u.fmem[2] = 8'h01;
		prog_u.fmem[3] = 8'h00;
		go();
		step(10);
		chk("fetches", 8'd6, 8'(prog_u.ptr));
		chk("idle clocks", 8'd16, 8'(prog_u.n_nop));
		chk("file 02", 8'h00, prog_u.fmem[2]);
		chk("file 03", 8'h01, prog_u.fmem[3]);
		chk("acc", 8'h00, working_accumulator_q);
		chk("flags", 8'h00, flg());
	endtask

	task automatic misc_ops();
		prog({14'h3003, 14'h0284, 14'h0904, 14'h0e84, 14'h0a84, 14'h0384, 14'h0804, 14'h0184,
			14'h3101});
		prog_u.fmem[4] = 8'h5c;
		go();
		step(3);
		chk("acc", 8'ha6, working_accumulator_q);
		chk("file 04", 8'h59, prog_u.fmem[4]);
		chk("flags", 8'h06, flg());
		step(6);
		chk("acc", 8'h95, working_accumulator_q);
		chk("file 04", 8'h00, prog_u.fmem[4]);
		chk("flags", 8'h07, flg());
		chk("reads", 8'd7, 8'(prog_u.n_rd));
		chk("writes", 8'd5, 8'(prog_u.n_wr));
		chk("upper pc", 8'h00, {1'b0, upper_pc_latch_q});
	endtask

	// Bit 14 of each entry marks an indirect access into program memory
	task automatic timing();
		logic [IW:0] tw [11];
		int tc [11];
		tw = '{15'h2000, 15'h000a, 15'h0008, 15'h0009, 15'h3477, 15'h2800, 15'h3200,
			15'h000b, 15'h3001, 15'h4400, 15'h6000};
		tc = '{2, 2, 2, 2, 2, 2, 2, 2, 1, 2, 3};
		for (int i = 0; i < 11; i++) begin
			prog({tw[i][IW-1:0]});
			prog_u.ind_mem[0] = tw[i][IW];
			go();
			step(3);
			chk("fetches", 8'(4 - tc[i]), 8'(prog_u.ptr));
			chk("idle clocks", 8'(4 * tc[i] - 4), 8'(prog_u.n_nop));
			chk("phase", 8'h01, {6'h00, phase_q});
		end
	endtask

	// Whole run needs about 650 clocks
	initial begin
		repeat (5000) @(posedge clk);
		bad_count++;
		complete_run();
	end

	initial begin
		lit_ops();
		byte_ops();
		shift_ops();
		skip_ops();
		misc_ops();
		timing();
		complete_run();
	end
endmodule
`default_nettype wire
